// >>> pkg/leased_line_pkg.sv
// Constants shared by the structured leased-line mapper
package leased_line_pkg;
  // ----------------------------------------------------------------
  // Frame layout
  // ----------------------------------------------------------------
  localparam int CORE_BYTES = 144;
  localparam int APP_BYTES = 128;
  localparam int STUFF_BYTES = 16;
  localparam int STUFF_GROUP = CORE_BYTES / STUFF_BYTES;
  localparam int INDEX_W = 8;
  localparam logic [INDEX_W-1:0] LAST_INDEX = 8'h8F;
  localparam int SPARE_FIRST = 9;
  localparam int SPARE_LAST = 48;
  localparam int SPARE_W = SPARE_LAST - SPARE_FIRST + 1;
  localparam logic [SPARE_W-1:0] SPARE_ONES = {SPARE_W{1'b1}};
  localparam logic [7:0] STUFF_BYTE = 8'hFF;
  localparam logic [7:0] AIS_BYTE = 8'hFF;
  localparam logic [7:0] AUX_BYTE = 8'h55;
  localparam int NUM_PAIRS = 3;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_KHZ = 40000;
  localparam int APP_RATE_KHZ = 2048;
  localparam int CLOCK_TOL_PPM = 50;
  localparam int FRAME_US = 500;
  localparam int FRAME_CYCLES = FRAME_US * CLK_KHZ / 1000;
  localparam int TOTAL_DELAY_US = 1250;
  localparam int TERMINAL_DELAY_US = 450;
  localparam int REPEATER_DELAY_US = 200;
  localparam int LINE_DELAY_US = 150;
  localparam int TERMINAL_DELAY_CYCLES = TERMINAL_DELAY_US * CLK_KHZ / 1000;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 5'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 5'h04;
  localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR = 5'h08;
  localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR = 5'h0C;
  localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR = 5'h10;
  localparam int CTRL_LTU_BIT = 0;
  localparam int CTRL_AUX_BIT = 1;
  localparam int CTRL_LOOP_ALLOW_BIT = 2;
  localparam logic [2:0] CTRL_RESET = 3'h5;
  localparam int ST_OPER_BIT = 0;
  localparam int ST_ALARM_BIT = 1;
  localparam int ST_LOOP_BIT = 2;
  localparam int EV_NONOP = 0;
  localparam int EV_ALARM = 1;
  localparam int EV_LOOP = 2;
  localparam int EV_UNDERRUN = 3;
  localparam int EV_DELAY = 4;
  localparam int NUM_EVENTS = 5;
endpackage

// >>> rtl/core_frame_position.sv
// Byte position counter of the 144-byte core frame with stuffing decode
`timescale 1ns/1ps
module core_frame_position (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic advance,
  output logic [leased_line_pkg::INDEX_W-1:0] index,
  output logic is_stuff
);
  import leased_line_pkg::*;

  // First byte of every group of nine carries stuffing
  function automatic logic stuff_slot(input logic [INDEX_W-1:0] idx);
    stuff_slot = (idx % INDEX_W'(STUFF_GROUP)) == '0;
  endfunction

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      index <= '0;
    end else if (restart) begin
      // A restart that carries a byte already counts that byte
      index <= advance ? INDEX_W'(1) : '0;
    end else if (advance) begin
      index <= (index == LAST_INDEX) ? '0 : index + 1'b1;
    end
  end

  assign is_stuff = stuff_slot(index);
endmodule // core_frame_position

// >>> rtl/structured_leased_line_mapper.sv
// Structured leased-line mapper into the transceiver core frame
//
// Behaviour
// - Payload fills a 144-byte core frame, transparently
// - Sixteen stuffing bytes per frame are all ONE
// - Spare frame bits nine to 48 sent ONE
// - Operational needs activation, pair identity, no failure
// - Any single pair failure means non-operational
// - Remote-end output undefined until all pairs active
// - Line alarm sends AIS or auxiliary pattern, at the line termination only
// - Loop request loops back every line transceiver
// - Loopback at line, owned by maintenance control
// - Mean one-way transfer delay at most 1250 us
// - Terminal 450, repeater 200, line 150 us
// - Frame timing counted on the 40000 kHz system clock, not the 2048 kHz reference
// - Test sequence in slots 1-31 passes error-free
// - Frame structure passed in its published order
`timescale 1ns/1ps
module structured_leased_line_mapper #(
  parameter int FRAME_CYCLES_P = leased_line_pkg::FRAME_CYCLES,
  parameter int DELAY_CYCLES_P = leased_line_pkg::TERMINAL_DELAY_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [leased_line_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [7:0] app_tx_byte,
  input wire logic app_tx_valid,
  output logic app_tx_ready,
  output logic [7:0] app_rx_byte,
  output logic app_rx_valid,
  input wire logic app_loop_req,
  output logic [7:0] core_tx_byte,
  output logic core_tx_valid,
  output logic core_tx_frame_start,
  output logic [leased_line_pkg::SPARE_W-1:0] spare_frame_bits,
  input wire logic [7:0] line_rx_byte,
  input wire logic line_rx_valid,
  input wire logic line_rx_frame_start,
  input wire logic [leased_line_pkg::NUM_PAIRS-1:0] pair_active,
  input wire logic [leased_line_pkg::NUM_PAIRS-1:0] pair_id_ok,
  input wire logic [leased_line_pkg::NUM_PAIRS-1:0] pair_fail,
  input wire logic [leased_line_pkg::NUM_PAIRS-1:0] pair_los_lfa,
  input wire logic other_failure,
  output logic [leased_line_pkg::NUM_PAIRS-1:0] pair_loopback,
  output logic section_operational
);
  import leased_line_pkg::*;

  localparam int BYTE_CYCLES = FRAME_CYCLES_P / CORE_BYTES;
  localparam int FRAME_W = $clog2(FRAME_CYCLES_P + 1);
  localparam int DELAY_W = $clog2(DELAY_CYCLES_P + 1);

  // ----------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------
  logic [2:0] ctrl;
  logic [NUM_EVENTS-1:0] irq_status;
  logic [NUM_EVENTS-1:0] irq_enable;
  logic [NUM_EVENTS-1:0] events;
  logic bus_ack;
  logic bus_req;
  logic wr_take;
  logic line_alarm;

  assign bus_req = avs_read | avs_write;
  // One wait state on every access; the answer lands on the second edge
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign wr_take = avs_write & bus_ack;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      avs_readdata <= '0;
    end else if (avs_read & ~bus_ack) begin
      if (avs_address == CTRL_ADDR) begin
        avs_readdata <= {29'h0, ctrl};
      end else if (avs_address == STATUS_ADDR) begin
        avs_readdata <= {29'h0, pair_loopback[0], line_alarm, section_operational};
      end else if (avs_address == IRQ_STATUS_ADDR) begin
        avs_readdata <= {27'h0, irq_status};
      end else if (avs_address == IRQ_ENABLE_ADDR) begin
        avs_readdata <= {27'h0, irq_enable};
      end else begin
        avs_readdata <= '0;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= CTRL_RESET;
      irq_enable <= '0;
    end else if (wr_take & avs_byteenable[0]) begin
      if (avs_address == CTRL_ADDR) begin
        ctrl <= avs_writedata[2:0];
      end else if (avs_address == IRQ_ENABLE_ADDR) begin
        irq_enable <= avs_writedata[NUM_EVENTS-1:0];
      end
    end
  end

  // A new event wins over a clear written in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status <= '0;
    end else if (wr_take & avs_byteenable[0] & (avs_address == IRQ_CLEAR_ADDR)) begin
      irq_status <= (irq_status & ~avs_writedata[NUM_EVENTS-1:0]) | events;
    end else begin
      irq_status <= irq_status | events;
    end
  end

  assign irq = |(irq_status & irq_enable);

  // ----------------------------------------------------------------
  // Section state and maintenance
  // ----------------------------------------------------------------
  logic all_good;
  logic loop_on;
  logic next_loop;

  // Any one pair failing drops the section at once
  assign all_good = (&pair_active) & (&pair_id_ok) & ~(|pair_fail) & ~other_failure;
  assign next_loop = app_loop_req & ctrl[CTRL_LOOP_ALLOW_BIT] & ctrl[CTRL_LTU_BIT];

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      section_operational <= 1'b0;
      line_alarm <= 1'b0;
      loop_on <= 1'b0;
      pair_loopback <= '0;
    end else begin
      section_operational <= all_good;
      line_alarm <= |pair_los_lfa;
      loop_on <= next_loop;
      pair_loopback <= {NUM_PAIRS{next_loop}};
    end
  end

  assign events[EV_NONOP] = section_operational & ~all_good;
  assign events[EV_ALARM] = ~line_alarm & (|pair_los_lfa);
  assign events[EV_LOOP] = loop_on ^ next_loop;

  // ----------------------------------------------------------------
  // Transmit framing
  // ----------------------------------------------------------------
  logic [FRAME_W-1:0] frame_cnt;
  logic [7:0] slot_cnt;
  logic frame_tick;
  logic [INDEX_W-1:0] tx_index;
  logic tx_is_stuff;
  logic [7:0] hold_byte;
  logic hold_full;
  logic [DELAY_W-1:0] hold_age;
  logic drain;

  // Frame period counted in system clock cycles, byte slots evenly spaced
  assign frame_tick = frame_cnt == FRAME_W'(FRAME_CYCLES_P - 1);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame_cnt <= '0;
      slot_cnt <= '0;
    end else begin
      frame_cnt <= frame_tick ? '0 : frame_cnt + 1'b1;
      slot_cnt <= (frame_tick | slot_cnt == 8'(BYTE_CYCLES - 1)) ? '0 : slot_cnt + 1'b1;
    end
  end

  logic tx_done;
  logic tx_emit;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_done <= 1'b0;
    end else if (frame_tick) begin
      tx_done <= 1'b0;
    end else if (tx_emit & tx_index == LAST_INDEX) begin
      tx_done <= 1'b1;
    end
  end
  // Emit at the start of each slot so the last byte lands before the frame tick
  assign tx_emit = (slot_cnt == '0) & ~tx_done & ~frame_tick;

  core_frame_position tx_pos (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(frame_tick),
    .advance(tx_emit),
    .index(tx_index),
    .is_stuff(tx_is_stuff)
  );

  assign drain = tx_emit & ~tx_is_stuff;
  // One holding byte only; the source stalls until it is free
  assign app_tx_ready = ~hold_full;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_byte <= '0;
      hold_full <= 1'b0;
    end else if (app_tx_valid & app_tx_ready) begin
      hold_byte <= app_tx_byte;
      hold_full <= 1'b1;
    end else if (drain) begin
      hold_full <= 1'b0;
    end
  end

  // Age of the waiting byte, checked against the terminal delay share
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hold_age <= '0;
    end else if (~hold_full | drain) begin
      hold_age <= '0;
    end else if (hold_age != DELAY_W'(DELAY_CYCLES_P)) begin
      hold_age <= hold_age + 1'b1;
    end
  end
  assign events[EV_DELAY] = hold_full & ~drain & (hold_age == DELAY_W'(DELAY_CYCLES_P - 1));
  assign events[EV_UNDERRUN] = drain & ~hold_full;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      core_tx_byte <= STUFF_BYTE;
      core_tx_valid <= 1'b0;
      core_tx_frame_start <= 1'b0;
      spare_frame_bits <= SPARE_ONES;
    end else begin
      core_tx_valid <= tx_emit;
      core_tx_frame_start <= tx_emit & (tx_index == '0);
      spare_frame_bits <= SPARE_ONES;
      if (tx_emit) begin
        if (tx_is_stuff) begin
          core_tx_byte <= STUFF_BYTE;
        end else if (hold_full) begin
          core_tx_byte <= hold_byte;
        end else begin
          core_tx_byte <= AIS_BYTE;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive deframing
  // ----------------------------------------------------------------
  logic rx_is_stuff;

  core_frame_position rx_pos (
    .sys_clk(sys_clk),
    .rst(rst),
    .restart(line_rx_frame_start),
    .advance(line_rx_valid),
    .index(),
    .is_stuff(rx_is_stuff)
  );

  logic rx_payload;
  // A frame start byte sits at position zero, which is always stuffing
  assign rx_payload = line_rx_valid & ~line_rx_frame_start & ~rx_is_stuff;

  // Only the line termination substitutes; the remote end passes data as is
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      app_rx_byte <= AIS_BYTE;
      app_rx_valid <= 1'b0;
    end else begin
      app_rx_valid <= rx_payload;
      if (rx_payload) begin
        if (ctrl[CTRL_LTU_BIT] & (|pair_los_lfa)) begin
          app_rx_byte <= ctrl[CTRL_AUX_BIT] ? AUX_BYTE : AIS_BYTE;
        end else begin
          app_rx_byte <= line_rx_byte;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [7:0] tx_frame_bytes;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_frame_bytes <= '0;
    end else if (core_tx_valid) begin
      tx_frame_bytes <= core_tx_frame_start ? 8'h01 : tx_frame_bytes + 8'h01;
    end
  end

  sequence bus_wait_s;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence
  sequence alarm_sub_s;
    rx_payload && ctrl[CTRL_LTU_BIT] && (|pair_los_lfa);
  endsequence

  bus_answer_a: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(bus_req) && !bus_ack |-> bus_wait_s) else $error("bus answer not after one wait");
  stuff_ones_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_emit && tx_is_stuff |=> core_tx_valid && core_tx_byte == STUFF_BYTE) else $error("stuff byte not ones");
  spare_ones_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 spare_frame_bits == SPARE_ONES) else $error("spare bits not ones");
  // The first frame after reset has no earlier count to judge
  frame_length_a: assert property (@(posedge sys_clk) disable iff (rst)
    core_tx_frame_start && tx_frame_bytes != 8'h00 |-> tx_frame_bytes == 8'(CORE_BYTES))
    else $error("core frame length wrong");
  oper_ok_a: assert property (@(posedge sys_clk) disable iff (rst)
    (&pair_active) && (&pair_id_ok) && !(|pair_fail) && !other_failure |=> section_operational)
    else $error("section not operational");
  nonop_fast_a: assert property (@(posedge sys_clk) disable iff (rst)
    !(&pair_active) || !(&pair_id_ok) || (|pair_fail) |=> !section_operational)
    else $error("failed pair not flagged");
  alarm_pattern_a: assert property (@(posedge sys_clk) disable iff (rst)
    alarm_sub_s |=> app_rx_valid && app_rx_byte == (ctrl[CTRL_AUX_BIT] ? AUX_BYTE : AIS_BYTE))
    else $error("alarm pattern not sent");
  loop_all_a: assert property (@(posedge sys_clk) disable iff (rst)
    next_loop |=> pair_loopback == {NUM_PAIRS{1'b1}}) else $error("loopback not on all pairs");
  loop_off_a: assert property (@(posedge sys_clk) disable iff (rst)
    !next_loop |=> pair_loopback == '0) else $error("loopback without request");
  delay_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    events[EV_DELAY] |=> irq_status[EV_DELAY]) else $error("delay overrun not flagged");
  irq_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    |(irq_status & irq_enable) |-> irq) else $error("interrupt not raised");
endmodule // structured_leased_line_mapper

// >>> testbench/app_side_model.sv
// Application-side equipment model facing the leased-line mapper
`timescale 1ns/1ps
module app_side_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hold_off,
  input wire logic loop_cmd,
  input wire logic app_tx_ready,
  input wire logic [7:0] app_rx_byte,
  input wire logic app_rx_valid,
  output logic [7:0] app_tx_byte,
  output logic app_tx_valid,
  output logic app_loop_req,
  output logic [7:0] rx_last,
  output logic [15:0] rx_count
);
  logic [7:0] seq;
  // Loop request is a level held for as long as the operator wants it
  assign app_loop_req = loop_cmd;
  // Offers a counting stream; a byte stays until taken, an idle line shows the inverse
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      seq <= 8'h00;
      app_tx_valid <= 1'b0;
      app_tx_byte <= 8'hFF;
    end else if (app_tx_valid && app_tx_ready) begin
      seq <= seq + 8'h01;
      app_tx_valid <= !hold_off;
      app_tx_byte <= hold_off ? ~seq : seq + 8'h01;
    end else if (!app_tx_valid && !hold_off) begin
      app_tx_valid <= 1'b1;
      app_tx_byte <= seq;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rx_last <= 8'h00;
      rx_count <= 16'h0000;
    end else if (app_rx_valid) begin
      rx_last <= app_rx_byte;
      rx_count <= rx_count + 16'h0001;
    end
  end
endmodule // app_side_model

// >>> testbench/structured_leased_line_mapper_tb_top.sv
// Self-checking bench for the structured leased-line mapper
`timescale 1ns/1ps
module structured_leased_line_mapper_tb_top;
  import leased_line_pkg::*;
  // Short frame keeps the run small: ten cycles per core byte
  localparam int FC = 1440;
  logic sys_clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0] avs_byteenable;
  logic [7:0] app_tx_byte, app_rx_byte, core_tx_byte, line_rx_byte, rx_last;
  logic app_tx_valid, app_tx_ready, app_rx_valid, app_loop_req, core_tx_valid, core_tx_frame_start;
  logic line_rx_valid, line_rx_frame_start, other_failure, section_operational, hold_off, loop_cmd;
  logic [SPARE_W-1:0] spare_frame_bits;
  logic [NUM_PAIRS-1:0] pair_active, pair_id_ok, pair_fail, pair_los_lfa, pair_loopback;
  logic [15:0] rx_count;
  int num_errors, checks;

  // Age limit below the gap across a stuffing slot, so held bytes trip the delay event
  structured_leased_line_mapper #(.FRAME_CYCLES_P(FC), .DELAY_CYCLES_P(15)) dut (.*);
  app_side_model partner (.*);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Bus and compare helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
    end
  endtask
  task automatic hang(input string what);
    $display("MISMATCH %s expected answer seen timeout", what);
    num_errors++;
    tally_and_finish();
  endtask
  // Request held until the edge that samples waitrequest low; no latency assumed
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    if (avs_waitrequest !== 1'b0) hang("bus answer");
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(negedge sys_clk);
  endtask
  task automatic set_pairs(input logic [2:0] act, id, fl, input logic oth);
    @(posedge sys_clk);
    pair_active <= act;
    pair_id_ok <= id;
    pair_fail <= fl;
    other_failure <= oth;
    repeat (2) @(negedge sys_clk);
  endtask
  // Byte 0 of a received frame is stuffing, byte 1 is payload
  task automatic line_byte(input logic [7:0] b);
    logic [15:0] c0;
    int n;
    c0 = rx_count;
    n = 0;
    @(posedge sys_clk);
    line_rx_frame_start <= 1'b1;
    line_rx_valid <= 1'b1;
    line_rx_byte <= 8'hFF;
    @(posedge sys_clk);
    line_rx_frame_start <= 1'b0;
    line_rx_byte <= b;
    @(posedge sys_clk);
    line_rx_valid <= 1'b0;
    line_rx_byte <= ~b;
    while (rx_count === c0 && n < 10) begin
      @(negedge sys_clk);
      n++;
    end
    if (rx_count === c0) hang("receive payload");
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_reset;
    chk("spare bits", SPARE_ONES, spare_frame_bits);
    chk("loopback idle", 0, pair_loopback);
    chk("not operational", 0, section_operational);
    bus(0, CTRL_ADDR, 0);
    chk("ctrl reset", CTRL_RESET, rd[2:0]);
    bus(0, 5'h14, 0);
    chk("unmapped read", 0, rd);
    bus(1, IRQ_CLEAR_ADDR, 32'h1F);
    bus(1, IRQ_STATUS_ADDR, 32'h1F);
    bus(0, IRQ_STATUS_ADDR, 0);
    chk("status not writable", 0, rd[2:0]);
    $display("test reset done");
  endtask
  task automatic test_frame;
    logic [7:0] prev;
    int idx, pay, bad_stuff, bad_pay, n;
    idx = 0;
    pay = 0;
    bad_stuff = 0;
    bad_pay = 0;
    n = 0;
    while (idx < CORE_BYTES && n < 3 * FC) begin
      @(negedge sys_clk);
      n++;
      if (core_tx_valid === 1'b1 && (idx > 0 || core_tx_frame_start === 1'b1)) begin
        if (idx % 9 == 0) begin
          bad_stuff += (core_tx_byte !== STUFF_BYTE);
        end else begin
          bad_pay += (pay > 0 && core_tx_byte !== prev + 8'h01);
          prev = core_tx_byte;
          pay++;
        end
        idx++;
      end
    end
    if (idx < CORE_BYTES) hang("core frame");
    chk("stuffing bytes", 0, bad_stuff);
    chk("payload order", 0, bad_pay);
    chk("payload count", APP_BYTES, pay);
    chk("spare bits in frame", SPARE_ONES, spare_frame_bits);
    bus(0, IRQ_STATUS_ADDR, 0);
    chk("delay event", 1, rd[EV_DELAY]);
    $display("test frame done");
  endtask
  task automatic test_oper;
    logic [2:0] bad;
    bus(1, IRQ_ENABLE_ADDR, 32'h1);
    for (int k = 0; k < 10; k++) begin
      set_pairs(3'h7, 3'h7, 3'h0, 1'b0);
      chk("operational", 1, section_operational);
      bad = 3'h1 << (k % 3);
      case (k / 3)
        0: set_pairs(~bad, 3'h7, 3'h0, 1'b0);
        1: set_pairs(3'h7, ~bad, 3'h0, 1'b0);
        2: set_pairs(3'h7, 3'h7, bad, 1'b0);
        default: set_pairs(3'h7, 3'h7, 3'h0, 1'b1);
      endcase
      chk("one fault", 0, section_operational);
    end
    chk("irq on loss", 1, irq);
    bus(1, IRQ_CLEAR_ADDR, 32'h1);
    chk("irq cleared", 0, irq);
    bus(1, IRQ_ENABLE_ADDR, 32'h0);
    set_pairs(3'h7, 3'h7, 3'h0, 1'b0);
    set_pairs(3'h7, 3'h7, 3'h4, 1'b0);
    chk("irq masked", 0, irq);
    bus(0, IRQ_STATUS_ADDR, 0);
    chk("loss event", 1, rd[EV_NONOP]);
    bus(1, IRQ_CLEAR_ADDR, 32'h1F);
    $display("test operational done");
  endtask
  task automatic test_alarm;
    line_byte(8'h3C);
    chk("payload through", 8'h3C, rx_last);
    bus(1, IRQ_ENABLE_ADDR, 32'h2);
    set_pairs(3'h7, 3'h7, 3'h0, 1'b0);
    @(posedge sys_clk);
    pair_los_lfa <= 3'h2;
    repeat (2) @(negedge sys_clk);
    chk("irq on alarm", 1, irq);
    bus(0, STATUS_ADDR, 0);
    chk("alarm status", 1, rd[ST_ALARM_BIT]);
    line_byte(8'h3C);
    chk("alarm signal", AIS_BYTE, rx_last);
    bus(1, CTRL_ADDR, 32'h7);
    line_byte(8'h3C);
    chk("aux pattern", AUX_BYTE, rx_last);
    @(posedge sys_clk);
    pair_los_lfa <= 3'h0;
    bus(1, IRQ_CLEAR_ADDR, 32'h2);
    chk("alarm irq cleared", 0, irq);
    bus(1, CTRL_ADDR, CTRL_RESET);
    $display("test alarm done");
  endtask
  task automatic test_loop;
    @(posedge sys_clk);
    loop_cmd <= 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("loopback on", 3'h7, pair_loopback);
    bus(0, STATUS_ADDR, 0);
    chk("loop status", 1, rd[ST_LOOP_BIT]);
    bus(1, CTRL_ADDR, 32'h1);
    @(negedge sys_clk);
    chk("loop not allowed", 0, pair_loopback);
    bus(1, CTRL_ADDR, 32'h4);
    @(negedge sys_clk);
    chk("loop remote role", 0, pair_loopback);
    bus(1, CTRL_ADDR, CTRL_RESET);
    @(posedge sys_clk);
    loop_cmd <= 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("loopback off", 0, pair_loopback);
    $display("test loopback done");
  endtask
  task automatic test_underrun;
    hold_off <= 1'b1;
    repeat (FC) @(posedge sys_clk);
    bus(0, IRQ_STATUS_ADDR, 0);
    chk("underrun event", 1, rd[EV_UNDERRUN]);
    hold_off <= 1'b0;
    $display("test underrun done");
  endtask

  initial begin
    num_errors = 0;
    checks = 0;
    rst = 1'b1;
    {avs_read, avs_write} = 2'b00;
    {avs_address, avs_writedata, avs_byteenable} = {5'h00, 32'h0, 4'hF};
    {line_rx_valid, line_rx_frame_start, line_rx_byte} = {2'b00, 8'hFF};
    {pair_active, pair_id_ok, pair_fail, pair_los_lfa} = 12'h000;
    {other_failure, hold_off, loop_cmd} = 3'b000;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    test_reset();
    test_frame();
    test_oper();
    test_alarm();
    test_loop();
    test_underrun();
    tally_and_finish();
  end
endmodule // structured_leased_line_mapper_tb_top
